// >>> core/scrc_field.sv
`timescale 1ns/1ps
module scrc_field #(
	parameter int unsigned     W   = 8,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          wr_en,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic          ld_en,
	input  wire logic [W-1:0]  ld_data,
	output logic      [W-1:0]  q_r
);

	logic [W-1:0] q_nxt;

	// Host write is applied last so it overrides a same-cycle result load
	always_comb begin
		q_nxt = q_r;
		if (ld_en) begin
			q_nxt = ld_data;
		end
		if (wr_en) begin
			q_nxt = wr_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q_r <= RST;
		end else begin
			q_r <= q_nxt;
		end
	end

endmodule : scrc_field

// >>> core/scrc_pkg.sv
package scrc_pkg;

	localparam int unsigned SCRC_AW = 6;
	localparam int unsigned SCRC_DW = 8;

	typedef logic [SCRC_AW-1:0] scrc_addr_t;
	typedef logic [SCRC_DW-1:0] scrc_data_t;

	// Register offsets on the serial register port
	localparam scrc_addr_t SCRC_OFF_PUMP   = 6'h23;
	localparam scrc_addr_t SCRC_OFF_VCO    = 6'h24;
	localparam scrc_addr_t SCRC_OFF_COARSE = 6'h25;
	localparam scrc_addr_t SCRC_OFF_CTRL   = 6'h26;
	localparam scrc_addr_t SCRC_OFF_RC_HI  = 6'h27;
	localparam scrc_addr_t SCRC_OFF_RC_LO  = 6'h28;

	// Field positions and widths
	localparam int unsigned SCRC_PUMP_CFG_LSB = 6;
	localparam int unsigned SCRC_PUMP_CFG_W   = 2;
	localparam int unsigned SCRC_PUMP_EN_LSB  = 4;
	localparam int unsigned SCRC_PUMP_EN_W    = 2;
	localparam int unsigned SCRC_PUMP_CUR_LSB = 0;
	localparam int unsigned SCRC_PUMP_CUR_W   = 4;
	localparam int unsigned SCRC_VCO_HI_LSB   = 5;
	localparam int unsigned SCRC_VCO_HI_W     = 1;
	localparam int unsigned SCRC_VCO_CUR_LSB  = 0;
	localparam int unsigned SCRC_VCO_CUR_W    = 5;
	localparam int unsigned SCRC_COARSE_LSB   = 0;
	localparam int unsigned SCRC_COARSE_W     = 6;
	localparam int unsigned SCRC_CTRL_LSB     = 0;
	localparam int unsigned SCRC_CTRL_W       = 7;
	localparam int unsigned SCRC_RC_LSB       = 0;
	localparam int unsigned SCRC_RC_W         = 7;

	// Reset values
	localparam logic [1:0] SCRC_RST_PUMP_CFG = 2'h2;
	localparam logic [1:0] SCRC_RST_PUMP_EN  = 2'h2;
	localparam logic [3:0] SCRC_RST_PUMP_CUR = 4'h9;
	localparam logic [0:0] SCRC_RST_VCO_HI   = 1'h0;
	localparam logic [4:0] SCRC_RST_VCO_CUR  = 5'h0A;
	localparam logic [5:0] SCRC_RST_COARSE   = 6'h20;
	localparam logic [6:0] SCRC_RST_CTRL     = 7'h0D;
	localparam logic [6:0] SCRC_RST_RC_HI    = 7'h41;
	localparam logic [6:0] SCRC_RST_RC_LO    = 7'h00;

endpackage : scrc_pkg

// >>> core/scrc_regs.sv
// Overview of operation
// - Pump register bits 7:6 configuration, reset 2
// - Pump register bits 5:4 stage enable, reset 2
// - Pump register bits 3:0 current result, reset 9
// - Calibration results stay readable after calibration
// - Host writes to results drive synthesizer directly
// - VCO register bit 5 high core select, reset 0
// - VCO register bits 4:0 current result, reset 10
// - Coarse register bits 5:0 capacitor array, reset 32
// - Control register bits 6:0 read/write, reset 13
// - RC high register bits 6:0, reset 65
// - RC low register bits 6:0, reset 0
`timescale 1ns/1ps
module scrc_regs
	import scrc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire scrc_addr_t  reg_addr,
	input  wire scrc_data_t  reg_wdata,
	output scrc_data_t       reg_rdata_r,
	output logic             reg_rvalid_r,
	input  wire logic        cal_load,
	input  wire logic [3:0]  cal_pump_current,
	input  wire logic [4:0]  cal_vco_current,
	input  wire logic [5:0]  cal_coarse_tune,
	output logic [1:0]       synth_cal_cfg,
	output logic [1:0]       pump_current_cal_enable,
	output logic [3:0]       pump_current,
	output logic             vco_high_core_select,
	output logic [4:0]       vco_current,
	output logic [5:0]       coarse_tune,
	output logic [6:0]       synth_cal_control,
	output logic [6:0]       rc_osc_config_hi,
	output logic [6:0]       rc_osc_config_lo
);

	function automatic logic scrc_sel(input scrc_addr_t a,
	                                  input scrc_addr_t off);
		return a == off;
	endfunction : scrc_sel

	logic        wr_pump;
	logic        wr_vco;
	logic        wr_coarse;
	logic        wr_ctrl;
	logic        wr_rc_hi;
	logic        wr_rc_lo;
	scrc_data_t  rdata_nxt;
	logic        rvalid_nxt;
	scrc_data_t  rd_mux;

	assign wr_pump   = reg_wr & scrc_sel(reg_addr, SCRC_OFF_PUMP);
	assign wr_vco    = reg_wr & scrc_sel(reg_addr, SCRC_OFF_VCO);
	assign wr_coarse = reg_wr & scrc_sel(reg_addr, SCRC_OFF_COARSE);
	assign wr_ctrl   = reg_wr & scrc_sel(reg_addr, SCRC_OFF_CTRL);
	assign wr_rc_hi  = reg_wr & scrc_sel(reg_addr, SCRC_OFF_RC_HI);
	assign wr_rc_lo  = reg_wr & scrc_sel(reg_addr, SCRC_OFF_RC_LO);

	// Only the field slices are stored, so reserved write bits vanish
	scrc_field #(.W(SCRC_PUMP_CFG_W), .RST(SCRC_RST_PUMP_CFG)) u_pump_cfg (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_pump),
		.wr_data (reg_wdata[SCRC_PUMP_CFG_LSB +: SCRC_PUMP_CFG_W]),
		.ld_en   (1'b0),
		.ld_data (2'h0),
		.q_r     (synth_cal_cfg)
	);

	scrc_field #(.W(SCRC_PUMP_EN_W), .RST(SCRC_RST_PUMP_EN)) u_pump_en (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_pump),
		.wr_data (reg_wdata[SCRC_PUMP_EN_LSB +: SCRC_PUMP_EN_W]),
		.ld_en   (1'b0),
		.ld_data (2'h0),
		.q_r     (pump_current_cal_enable)
	);

	// Result fields load from calibration and from the host
	scrc_field #(.W(SCRC_PUMP_CUR_W), .RST(SCRC_RST_PUMP_CUR)) u_pump_cur (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_pump),
		.wr_data (reg_wdata[SCRC_PUMP_CUR_LSB +: SCRC_PUMP_CUR_W]),
		.ld_en   (cal_load),
		.ld_data (cal_pump_current),
		.q_r     (pump_current)
	);

	scrc_field #(.W(SCRC_VCO_HI_W), .RST(SCRC_RST_VCO_HI)) u_vco_hi (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_vco),
		.wr_data (reg_wdata[SCRC_VCO_HI_LSB +: SCRC_VCO_HI_W]),
		.ld_en   (1'b0),
		.ld_data (1'h0),
		.q_r     (vco_high_core_select)
	);

	scrc_field #(.W(SCRC_VCO_CUR_W), .RST(SCRC_RST_VCO_CUR)) u_vco_cur (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_vco),
		.wr_data (reg_wdata[SCRC_VCO_CUR_LSB +: SCRC_VCO_CUR_W]),
		.ld_en   (cal_load),
		.ld_data (cal_vco_current),
		.q_r     (vco_current)
	);

	scrc_field #(.W(SCRC_COARSE_W), .RST(SCRC_RST_COARSE)) u_coarse (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_coarse),
		.wr_data (reg_wdata[SCRC_COARSE_LSB +: SCRC_COARSE_W]),
		.ld_en   (cal_load),
		.ld_data (cal_coarse_tune),
		.q_r     (coarse_tune)
	);

	scrc_field #(.W(SCRC_CTRL_W), .RST(SCRC_RST_CTRL)) u_ctrl (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_ctrl),
		.wr_data (reg_wdata[SCRC_CTRL_LSB +: SCRC_CTRL_W]),
		.ld_en   (1'b0),
		.ld_data (7'h00),
		.q_r     (synth_cal_control)
	);

	scrc_field #(.W(SCRC_RC_W), .RST(SCRC_RST_RC_HI)) u_rc_hi (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_rc_hi),
		.wr_data (reg_wdata[SCRC_RC_LSB +: SCRC_RC_W]),
		.ld_en   (1'b0),
		.ld_data (7'h00),
		.q_r     (rc_osc_config_hi)
	);

	scrc_field #(.W(SCRC_RC_W), .RST(SCRC_RST_RC_LO)) u_rc_lo (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (wr_rc_lo),
		.wr_data (reg_wdata[SCRC_RC_LSB +: SCRC_RC_W]),
		.ld_en   (1'b0),
		.ld_data (7'h00),
		.q_r     (rc_osc_config_lo)
	);

	// Read mux; reserved positions are zero-filled
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			SCRC_OFF_PUMP: begin
				rd_mux = {synth_cal_cfg, pump_current_cal_enable,
				          pump_current};
			end
			SCRC_OFF_VCO: begin
				rd_mux = {2'h0, vco_high_core_select, vco_current};
			end
			SCRC_OFF_COARSE: begin
				rd_mux = {2'h0, coarse_tune};
			end
			SCRC_OFF_CTRL: begin
				rd_mux = {1'h0, synth_cal_control};
			end
			SCRC_OFF_RC_HI: begin
				rd_mux = {1'h0, rc_osc_config_hi};
			end
			SCRC_OFF_RC_LO: begin
				rd_mux = {1'h0, rc_osc_config_lo};
			end
			default: begin
				// Unmapped addresses answer zero rather than stale data
				rd_mux = 8'h00;
			end
		endcase
	end

	// Read data is held until the next read so a slow shifter can use it
	always_comb begin
		rdata_nxt  = reg_rdata_r;
		rvalid_nxt = reg_rd;
		if (reg_rd) begin
			rdata_nxt = rd_mux;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_r  <= 8'h00;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rdata_r  <= rdata_nxt;
			reg_rvalid_r <= rvalid_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_pump_cfg_wr;
		wr_pump |=> synth_cal_cfg ==
			$past(reg_wdata[SCRC_PUMP_CFG_LSB +: SCRC_PUMP_CFG_W]);
	endproperty
	a_pump_cfg_wr: assert property (p_pump_cfg_wr)
		else $error("pump config field did not take write");

	property p_pump_en_wr;
		wr_pump |=> pump_current_cal_enable ==
			$past(reg_wdata[SCRC_PUMP_EN_LSB +: SCRC_PUMP_EN_W]);
	endproperty
	a_pump_en_wr: assert property (p_pump_en_wr)
		else $error("pump enable field did not take write");

	property p_pump_cal_load;
		(cal_load && !wr_pump) |=> pump_current == $past(cal_pump_current);
	endproperty
	a_pump_cal_load: assert property (p_pump_cal_load)
		else $error("pump current result not loaded");

	property p_pump_readback;
		(reg_rd && scrc_sel(reg_addr, SCRC_OFF_PUMP)) |=> reg_rvalid_r &&
			reg_rdata_r == {$past(synth_cal_cfg),
			$past(pump_current_cal_enable), $past(pump_current)};
	endproperty
	a_pump_readback: assert property (p_pump_readback)
		else $error("pump register readback mismatch");

	property p_coarse_hop;
		(wr_coarse && !reg_rd) ##1
			(reg_rd && scrc_sel(reg_addr, SCRC_OFF_COARSE) && !wr_coarse &&
			 !cal_load)
			|=> reg_rdata_r[5:0] == $past(reg_wdata[5:0], 2);
	endproperty
	a_coarse_hop: assert property (p_coarse_hop)
		else $error("stored coarse value not read back");

	property p_vco_hi_wr;
		wr_vco |=> vco_high_core_select ==
			$past(reg_wdata[SCRC_VCO_HI_LSB]);
	endproperty
	a_vco_hi_wr: assert property (p_vco_hi_wr)
		else $error("vco core select did not take write");

	property p_vco_cur_wr;
		wr_vco |=> vco_current ==
			$past(reg_wdata[SCRC_VCO_CUR_LSB +: SCRC_VCO_CUR_W]);
	endproperty
	a_vco_cur_wr: assert property (p_vco_cur_wr)
		else $error("vco current override not applied");

	property p_coarse_load;
		(cal_load && !wr_coarse) |=> coarse_tune == $past(cal_coarse_tune);
	endproperty
	a_coarse_load: assert property (p_coarse_load)
		else $error("coarse tune result not loaded");

	property p_ctrl_hold;
		!wr_ctrl |=> $stable(synth_cal_control);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold)
		else $error("control field changed without a write");

	property p_rc_hi_read;
		(reg_rd && scrc_sel(reg_addr, SCRC_OFF_RC_HI)) |=>
			reg_rdata_r == {1'h0, $past(rc_osc_config_hi)};
	endproperty
	a_rc_hi_read: assert property (p_rc_hi_read)
		else $error("rc high readback mismatch");

	property p_rc_lo_wr;
		wr_rc_lo |=> rc_osc_config_lo == $past(reg_wdata[6:0]);
	endproperty
	a_rc_lo_wr: assert property (p_rc_lo_wr)
		else $error("rc low field did not take write");

	property p_vco_reserved;
		(reg_rd && scrc_sel(reg_addr, SCRC_OFF_VCO)) |=>
			reg_rdata_r[7:6] == 2'h0;
	endproperty
	a_vco_reserved: assert property (p_vco_reserved)
		else $error("vco reserved bits not zero");

	property p_unmapped_read;
		(reg_rd && (reg_addr < SCRC_OFF_PUMP || reg_addr > SCRC_OFF_RC_LO))
			|=> reg_rdata_r == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read not zero");

	c_cal_then_read: cover property (cal_load ##1
		(reg_rd && scrc_sel(reg_addr, SCRC_OFF_PUMP)));
	c_hop_write_read: cover property (wr_coarse ##1
		(reg_rd && scrc_sel(reg_addr, SCRC_OFF_COARSE)));
	c_write_vs_load: cover property (wr_coarse && cal_load);
	c_unmapped: cover property (reg_rd && reg_addr == 6'h29);

endmodule : scrc_regs

// >>> sim/scrc_host.sv
`timescale 1ns/1ps
module scrc_host
	import scrc_pkg::*;
(
	input  wire logic       clk,
	input  wire scrc_data_t reg_rdata_r,
	input  wire logic       reg_rvalid_r,
	output logic            reg_wr,
	output logic            reg_rd,
	output scrc_addr_t      reg_addr,
	output scrc_data_t      reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h3F;
		reg_wdata = 8'h5A;
	end
	// Idle lines show the inverse of the last value, so a stale
	// address or data byte can never pass for a fresh request
	task automatic wr(input scrc_addr_t a, input scrc_data_t d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input scrc_addr_t a, output scrc_data_t d,
		output logic v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		// Answer is taken mid-cycle, where it has settled
		@(negedge clk);
		v = reg_rvalid_r;
		d = reg_rdata_r;
	endtask : rd
	// Write then read the same place on the very next edge, as a hop does
	task automatic wr_rd(input scrc_addr_t a, input scrc_data_t d,
		output scrc_data_t q, output logic v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_wdata <= ~d;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		v = reg_rvalid_r;
		q = reg_rdata_r;
	endtask : wr_rd
endmodule : scrc_host

// >>> sim/synth_cal_rc_osc_config_regs_tb.sv
`timescale 1ns/1ps
module synth_cal_rc_osc_config_regs_tb
	import scrc_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cal_load = 1'b0;
	logic [3:0] cal_p = 4'h0;
	logic [4:0] cal_v = 5'h00;
	logic [5:0] cal_c = 6'h00;
	logic reg_wr, reg_rd, rv, hi;
	scrc_addr_t reg_addr;
	scrc_data_t reg_wdata, rdata;
	logic [1:0] cfg, en;
	logic [3:0] pc;
	logic [4:0] vc;
	logic [5:0] ct;
	logic [6:0] cc, rh, rl;
	scrc_data_t ex [64];
	scrc_data_t sv [3];
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] rs = 32'hEA05;
	scrc_data_t d;
	scrc_addr_t a;
	logic [31:0] r;

	initial forever #20 clk = ~clk;

	scrc_regs u_dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_r(rdata), .reg_rvalid_r(rv), .cal_load(cal_load),
		.cal_pump_current(cal_p), .cal_vco_current(cal_v),
		.cal_coarse_tune(cal_c), .synth_cal_cfg(cfg),
		.pump_current_cal_enable(en), .pump_current(pc),
		.vco_high_core_select(hi), .vco_current(vc), .coarse_tune(ct),
		.synth_cal_control(cc), .rc_osc_config_hi(rh),
		.rc_osc_config_lo(rl));
	scrc_host u_host (.clk(clk), .reg_rdata_r(rdata), .reg_rvalid_r(rv),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// Writable bits of each mapped byte; zero marks unmapped places
	function automatic scrc_data_t msk(scrc_addr_t x);
		case (x)
			6'h23: return 8'hFF;
			6'h24, 6'h25: return 8'h3F;
			6'h26, 6'h27, 6'h28: return 8'h7F;
			default: return 8'h00;
		endcase
	endfunction : msk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(scrc_data_t g, scrc_data_t w, string s);
		cmp_count++;
		if (g !== w) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, g, w);
		end
	endtask : chk
	task automatic rdchk(scrc_addr_t x);
		scrc_data_t g;
		logic v;
		u_host.rd(x, g, v);
		chk({7'h00, v}, 8'h01, "read valid");
		chk(g, ex[x], "read data");
	endtask : rdchk
	task automatic hw(scrc_addr_t x, scrc_data_t y);
		u_host.wr(x, y);
		ex[x] = y & msk(x);
	endtask : hw
	task automatic hwrd(scrc_addr_t x, scrc_data_t y);
		scrc_data_t g;
		logic v;
		u_host.wr_rd(x, y, g, v);
		ex[x] = y & msk(x);
		chk({7'h00, v}, 8'h01, "hop valid");
		chk(g, ex[x], "hop readback");
	endtask : hwrd
	task automatic outchk();
		@(negedge clk);
		chk({cfg, en, pc}, ex[6'h23], "pump fields");
		chk({2'h0, hi, vc}, ex[6'h24], "vco fields");
		chk({2'h0, ct}, ex[6'h25], "coarse field");
		chk({1'h0, cc}, ex[6'h26], "control field");
		chk({1'h0, rh}, ex[6'h27], "rc hi field");
		chk({1'h0, rl}, ex[6'h28], "rc lo field");
	endtask : outchk
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		foreach (ex[i]) ex[i] = 8'h00;
		ex[6'h23] = 8'hA9;
		ex[6'h24] = 8'h0A;
		ex[6'h25] = 8'h20;
		ex[6'h26] = 8'h0D;
		ex[6'h27] = 8'h41;
	endtask : do_reset
	// The calibration engine is played here; results sampled with the pulse
	task automatic cal(logic [3:0] p, logic [4:0] v, logic [5:0] c);
		@(posedge clk);
		cal_load <= 1'b1;
		{cal_p, cal_v, cal_c} <= {p, v, c};
		@(posedge clk);
		cal_load <= 1'b0;
		{cal_p, cal_v, cal_c} <= ~{p, v, c};
		ex[6'h23][3:0] = p;
		ex[6'h24][4:0] = v;
	endtask : cal

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	initial begin
		do_reset();
		outchk();
		for (int i = 6'h23; i <= 6'h28; i++) rdchk(6'(i));
		for (int i = 6'h22; i <= 6'h29; i++) begin
			hw(6'(i), 8'hFF);
			rdchk(6'(i));
		end
		outchk();
		repeat (60) begin
			r = rnd();
			a = r[0] ? r[6:1] : 6'(6'h23 + r[3:1] % 6);
			if (r[7]) hw(a, r[15:8]);
			else rdchk(a);
		end
		outchk();
		cal(4'hF, 5'h1F, 6'h3F);
		ex[6'h25][5:0] = 6'h3F;
		outchk();
		for (int i = 0; i < 3; i++) rdchk(6'(6'h23 + i));
		for (int i = 0; i < 3; i++) sv[i] = ex[6'h23 + i];
		r = rnd();
		cal(r[3:0], r[8:4], r[14:9]);
		ex[6'h25][5:0] = r[14:9];
		outchk();
		for (int i = 0; i < 3; i++) hw(6'(6'h23 + i), sv[i]);
		outchk();
		fork
			hw(6'h25, 8'h15);
			cal(4'h3, 5'h05, 6'h2A);
		join
		outchk();
		rdchk(6'h25);
		hwrd(6'h25, sv[2]);
		// Read the pump result on the edge right after the load
		fork
			cal(4'h6, 5'h11, 6'h0B);
			begin
				@(posedge clk);
				rdchk(6'h23);
			end
		join
		ex[6'h25][5:0] = 6'h0B;
		outchk();
		do_reset();
		outchk();
		rdchk(6'h23);
		report_and_stop();
	end
endmodule : synth_cal_rc_osc_config_regs_tb
